// File: smh_ctrl.sv
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - observed data set ready gates readiness for both sending and receiving
// - observed clear to send must be true before any character goes out
// - observed carrier detect gates acceptance of received characters
// - once ready, terminal ready and request to send are held true
// - autodisconnect forces terminal ready false for its whole duration unless the terminal ready override is enabled
// - auto request mode: request follows transmit buffer not empty
// - auto request drops after each line end and when the transmit buffer empties
// - send only while request and clear are both true
// - auto mode raises request only after clear is seen false; with clear ignored it is raised without waiting
// - stop on buffer empty, line end sent, or clear dropped
// - while not sending, receive is allowed if carrier detect true
// - local clear instruction or device clear restores stalled handshake
// - two-character line end recognised even with delete/insert off
// - default ignores all inputs and holds both outputs true
// - three-bit observe field selects each input individually
// - request to send true after startup and reset by default
// - input line states readable in three status bits
// - override enables 2 drive outputs from the value bits
// - overrides act per line independently
module smh_ctrl (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // register port
   input wire logic [smh_pkg::ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // serial pins
   input wire smh_pkg::smh_lines_s LINES_IN,
   output smh_pkg::smh_outs_s LINES_OUT,
   // transmit side
   input wire logic TX_VALID,
   input wire logic [7:0] TX_DATA,
   output logic TX_READY,
   output logic [7:0] TX_CHAR,
   output logic TX_CHAR_VALID,
   // receive side
   input wire logic RX_VALID,
   output logic RX_ACCEPT,
   // loop side clear and disconnect
   input wire logic DEV_CLEAR,
   input wire logic AUTODISC,
   output logic READY_TO_OPERATE
);
   import smh_pkg::*;

   // ****************************************************
   // input synchronisers
   // ****************************************************
   smh_lines_s sync;
   smh_sync u_dsr (.REF_CLK(REF_CLK), .RST_N(RST_N), .async_in(LINES_IN.dsr),
      .sync_out(sync.dsr));
   smh_sync u_cts (.REF_CLK(REF_CLK), .RST_N(RST_N), .async_in(LINES_IN.cts),
      .sync_out(sync.cts));
   smh_sync u_dcd (.REF_CLK(REF_CLK), .RST_N(RST_N), .async_in(LINES_IN.dcd),
      .sync_out(sync.dcd));

   // ****************************************************
   // registers
   // ****************************************************
   logic [3:0] override_r;
   logic [3:0] status_auto_r;
   logic [3:0] observe_r;
   logic [3:0] line_end_r;
   logic [7:0] eol_first_r;
   logic [7:0] eol_second_r;
   logic disc_r;
   logic clear_pulse;
   logic ready_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         override_r <= OVERRIDE_RST;
         status_auto_r <= NIBBLE_RST;
         observe_r <= NIBBLE_RST;
         line_end_r <= NIBBLE_RST;
         eol_first_r <= EOL_FIRST_RST;
         eol_second_r <= EOL_SECOND_RST;
         disc_r <= 1'b0;
      end else if (WR) begin
         case (ADDR)
            OFS_OVERRIDE: override_r <= WDATA[3:0];
            OFS_STATUS_AUTO: status_auto_r <= WDATA[3:0];
            OFS_OBSERVE: observe_r <= WDATA[3:0];
            OFS_LINE_END: line_end_r <= WDATA[3:0];
            OFS_EOL_FIRST: eol_first_r <= WDATA;
            OFS_EOL_SECOND: eol_second_r <= WDATA;
            OFS_CONTROL: disc_r <= WDATA[CTL_DISC_BIT];
            default: ;
         endcase
      end
   end

   // local clear instruction, a write-one pulse, or device clear
   assign clear_pulse = (WR && ADDR == OFS_CONTROL && WDATA[CTL_CLEAR_BIT]) || DEV_CLEAR;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= 1'b1;
      end
   end
   assign READY_TO_OPERATE = ready_r;

   // read data, one cycle later
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 8'h00;
      end else if (RD) begin
         case (ADDR)
            OFS_OVERRIDE: RDATA <= {4'h0, override_r};
            OFS_STATUS_AUTO: RDATA <= {4'h0, status_auto_r[AUTO_RTS_BIT],
               sync.dsr, sync.cts, sync.dcd};
            OFS_OBSERVE: RDATA <= {4'h0, observe_r};
            OFS_LINE_END: RDATA <= {4'h0, line_end_r};
            OFS_EOL_FIRST: RDATA <= eol_first_r;
            OFS_EOL_SECOND: RDATA <= eol_second_r;
            OFS_CONTROL: RDATA <= {6'h00, disc_r, 1'b0};
            default: RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

   // ****************************************************
   // gating
   // ****************************************************
   logic auto_rts;
   logic dsr_ok;
   logic cts_ok;
   logic dcd_ok;
   logic disc;

   // single enable, location chosen by package constant
   assign auto_rts = AUTO_RTS_IN_STATUS ? status_auto_r[AUTO_RTS_BIT]
                                        : line_end_r[LE_AUTO_RTS_BIT];
   // ignored lines read as true
   assign dsr_ok = !observe_r[OBS_DSR_BIT] || sync.dsr;
   assign cts_ok = !observe_r[OBS_CTS_BIT] || sync.cts;
   assign dcd_ok = !observe_r[OBS_DCD_BIT] || sync.dcd;
   assign disc = disc_r || AUTODISC;

   // ****************************************************
   // transmit sequencing
   // ****************************************************
   smh_tx_e state_r;
   logic rts_auto;
   logic sending;
   logic prev_first_r;
   logic eol_hit;
   logic tx_take;

   // own request pin must already stand true, so an override to false also stops sending
   assign sending = ready_r && dsr_ok && cts_ok && LINES_OUT.rts
      && (!auto_rts || state_r == SMH_SEND);
   assign TX_READY = sending;
   assign tx_take = TX_VALID && sending;
   // line end matched regardless of delete/insert options
   assign eol_hit = tx_take && prev_first_r && TX_DATA == eol_second_r;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         prev_first_r <= 1'b0;
      end else if (tx_take) begin
         prev_first_r <= TX_DATA == eol_first_r;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r <= SMH_IDLE;
      end else if (clear_pulse || !auto_rts) begin
         state_r <= SMH_IDLE;
      end else begin
         case (state_r)
            SMH_IDLE: if (TX_VALID) state_r <= SMH_WAIT_CTS_LOW;
            SMH_WAIT_CTS_LOW: if (!cts_ok || !observe_r[OBS_CTS_BIT])
               state_r <= SMH_SEND;
            SMH_SEND: begin
               if (eol_hit) state_r <= SMH_DROP;
               else if (!TX_VALID) state_r <= SMH_IDLE;
            end
            SMH_DROP: state_r <= SMH_IDLE;
            default: state_r <= SMH_IDLE;
         endcase
      end
   end

   // request asserted only in the send state under auto mode
   assign rts_auto = auto_rts ? (state_r == SMH_SEND) : 1'b1;

   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         TX_CHAR <= 8'h00;
         TX_CHAR_VALID <= 1'b0;
      end else begin
         TX_CHAR_VALID <= tx_take;
         if (tx_take) TX_CHAR <= TX_DATA;
      end
   end

   // ****************************************************
   // receive gating
   // ****************************************************
   // full duplex: receive never blocked by transmit
   assign RX_ACCEPT = RX_VALID && ready_r && dsr_ok && dcd_ok;

   // ****************************************************
   // output lines
   // ****************************************************
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         LINES_OUT <= '0;
      end else begin
         // each line overridden independently
         LINES_OUT.dtr <= override_r[OVR_DTR_EN_BIT] ? override_r[OVR_DTR_VAL_BIT]
            : (ready_r && !disc);
         LINES_OUT.rts <= override_r[OVR_RTS_EN_BIT] ? override_r[OVR_RTS_VAL_BIT]
            : (ready_r && rts_auto);
      end
   end

   // ****************************************************
   // checks
   // ****************************************************
   sequence s_eol_sent;
      eol_hit;
   endsequence
   sequence s_rts_low;
      ##2 !LINES_OUT.rts;
   endsequence
   // clear seen false while waiting, the cue to raise request
   sequence s_cts_seen_low;
      state_r == SMH_WAIT_CTS_LOW && auto_rts && !clear_pulse
         && observe_r[OBS_CTS_BIT] && !sync.cts;
   endsequence
   // pin follows the state one cycle later, unless an override owns it
   sequence s_rts_rises;
      state_r == SMH_SEND ##1 (LINES_OUT.rts || $past(override_r[OVR_RTS_EN_BIT]));
   endsequence
   // back-to-back line end pair; a gap between the two chars is not checked here
   sequence s_eol_pair;
      (tx_take && TX_DATA == eol_first_r) ##1 (tx_take && TX_DATA == eol_second_r);
   endsequence

   // a register write landing in the same cycle can upset these; the bench avoids it
   AST_DISC_DTR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      disc && !override_r[OVR_DTR_EN_BIT] |=> !LINES_OUT.dtr)
      else $error("terminal ready not dropped on disconnect");

   AST_CTS_GATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      observe_r[OBS_CTS_BIT] && !sync.cts |-> !TX_READY)
      else $error("sent while clear false");

   AST_DSR_GATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      observe_r[OBS_DSR_BIT] && !sync.dsr |-> !TX_READY && !RX_ACCEPT)
      else $error("active while set not ready");

   AST_DCD_GATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      RX_ACCEPT |-> (sync.dcd || !observe_r[OBS_DCD_BIT]))
      else $error("accepted without carrier");

   AST_EOL_DROP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      s_eol_sent and (auto_rts && !override_r[OVR_RTS_EN_BIT] && !clear_pulse)
      |-> s_rts_low)
      else $error("request not dropped after line end");

   AST_DEFAULT_RTS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ready_r && !auto_rts && !override_r[OVR_RTS_EN_BIT] |=> LINES_OUT.rts)
      else $error("request not held true");

   AST_OVR_RTS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      override_r[OVR_RTS_EN_BIT] |=> LINES_OUT.rts == $past(override_r[OVR_RTS_VAL_BIT]))
      else $error("override value not driven");

   AST_AUTO_SEND: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      auto_rts && TX_READY |-> state_r == SMH_SEND)
      else $error("sent without request");

   AST_CLEAR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      clear_pulse |=> state_r == SMH_IDLE)
      else $error("clear did not restore handshake");

   AST_DEFAULT_DTR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      ready_r && !disc && !override_r[OVR_DTR_EN_BIT] |=> LINES_OUT.dtr)
      else $error("terminal ready not held true");

   AST_OVR_DTR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      override_r[OVR_DTR_EN_BIT] |=> LINES_OUT.dtr == $past(override_r[OVR_DTR_VAL_BIT]))
      else $error("terminal ready override not driven");

   AST_AUTO_RTS_EMPTY: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      auto_rts && state_r == SMH_IDLE && !override_r[OVR_RTS_EN_BIT] |=> !LINES_OUT.rts)
      else $error("request true with empty buffer");

   AST_WAIT_CTS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      state_r == SMH_WAIT_CTS_LOW && auto_rts && !clear_pulse && observe_r[OBS_CTS_BIT]
      && sync.cts |=> state_r == SMH_WAIT_CTS_LOW)
      else $error("request raised while clear still true");

   AST_RTS_AFTER_WAIT: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      s_cts_seen_low |=> s_rts_rises)
      else $error("request not raised after clear seen false");

   AST_SEND_GATE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      TX_READY |-> LINES_OUT.rts && (sync.cts || !observe_r[OBS_CTS_BIT]))
      else $error("sent without both request and clear");

   AST_DRAIN: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      state_r == SMH_SEND && auto_rts && !TX_VALID |=> state_r == SMH_IDLE)
      else $error("send not ended on empty buffer");

   AST_RX_FREE: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      RX_VALID && ready_r && !TX_READY && dsr_ok && dcd_ok |-> RX_ACCEPT)
      else $error("receive refused while not sending");

   AST_STATUS: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      RD && ADDR == OFS_STATUS_AUTO |=> RDATA[2:0] == $past(sync))
      else $error("line status not readable");

   AST_TX_CHAR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      tx_take |=> TX_CHAR_VALID && TX_CHAR == $past(TX_DATA))
      else $error("taken char not passed on");

   AST_EOL_PAIR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
      s_eol_pair |-> eol_hit)
      else $error("line end pair not recognised");
endmodule

// File: smh_modem_model.sv
`timescale 1ns/1ps
module smh_modem_model (
   // clock
   input wire logic clk,
   // handshake
   input wire logic rts,
   input wire logic dsr_set,
   input wire logic dcd_set,
   input wire logic cts_allow,
   output smh_pkg::smh_lines_s lines
);
   import smh_pkg::*;
   logic cts_r;
   // clear only answers a raised request, one cycle late like a slow modem
   always_ff @(posedge clk) begin
      cts_r <= rts && cts_allow;
   end
   // clear falls in the same instant as request
   assign lines = '{dsr: dsr_set, cts: cts_r && rts, dcd: dcd_set};
endmodule

// File: smh_pkg.sv
package smh_pkg;
   // ****************************************************
   // register port
   // ****************************************************
   localparam int ADDR_W = 4;
   localparam logic [3:0] OFS_OVERRIDE = 4'h4;
   localparam logic [3:0] OFS_STATUS_AUTO = 4'h5;
   localparam logic [3:0] OFS_OBSERVE = 4'h9;
   localparam logic [3:0] OFS_LINE_END = 4'hA;
   localparam logic [3:0] OFS_EOL_FIRST = 4'hC;
   localparam logic [3:0] OFS_EOL_SECOND = 4'hD;
   localparam logic [3:0] OFS_CONTROL = 4'hE;
   // field positions
   localparam int OVR_DTR_EN_BIT = 3;
   localparam int OVR_RTS_EN_BIT = 2;
   localparam int OVR_DTR_VAL_BIT = 1;
   localparam int OVR_RTS_VAL_BIT = 0;
   localparam int AUTO_RTS_BIT = 3;
   localparam int OBS_DSR_BIT = 3;
   localparam int OBS_CTS_BIT = 2;
   localparam int OBS_DCD_BIT = 1;
   localparam int LE_DEL_BIT = 1;
   localparam int LE_AUTO_RTS_BIT = 0;
   localparam int CTL_CLEAR_BIT = 0;
   localparam int CTL_DISC_BIT = 1;
   // selects which register holds the auto request enable
   localparam bit AUTO_RTS_IN_STATUS = 1'b1;
   // reset values
   localparam logic [3:0] OVERRIDE_RST = 4'h0;
   localparam logic [3:0] NIBBLE_RST = 4'h0;
   localparam logic [7:0] EOL_FIRST_RST = 8'h0D;
   localparam logic [7:0] EOL_SECOND_RST = 8'h0A;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic dsr;
      logic cts;
      logic dcd;
   } smh_lines_s;

   typedef struct packed {
      logic dtr;
      logic rts;
   } smh_outs_s;

   typedef enum logic [1:0] {
      SMH_IDLE,
      SMH_WAIT_CTS_LOW,
      SMH_SEND,
      SMH_DROP
   } smh_tx_e;
endpackage

// File: smh_sync.sv
`timescale 1ns/1ps
module smh_sync (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST_N,
   // async level in, synced level out
   input wire logic async_in,
   output logic sync_out
);
   import smh_pkg::*;
   logic meta_r;

   // meta_r feeds only sync_out
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         meta_r <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// File: test_serial_modem_handshake_control.sv
`timescale 1ns/1ps
module test_serial_modem_handshake_control;
   import smh_pkg::*;
   logic REF_CLK = 1'b0;
   logic RST_N = 1'b0;
   logic [3:0] ADDR = 4'h0;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic TX_VALID = 1'b0;
   logic [7:0] TX_DATA = 8'h00;
   logic RX_VALID = 1'b0;
   logic DEV_CLEAR = 1'b0;
   logic AUTODISC = 1'b0;
   logic dsr = 1'b1;
   logic dcd = 1'b1;
   logic allow = 1'b1;
   logic [7:0] RDATA, TX_CHAR, d;
   logic TX_READY, TX_CHAR_VALID, READY_TO_OPERATE, RX_ACCEPT, lo;
   smh_lines_s LINES_IN;
   smh_outs_s LINES_OUT;
   logic [31:0] r = 32'ha919;
   logic [7:0] q[$];
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int i, k;
   always #20 REF_CLK = ~REF_CLK;
   smh_ctrl u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .LINES_IN(LINES_IN), .LINES_OUT(LINES_OUT),
      .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY), .TX_CHAR(TX_CHAR),
      .TX_CHAR_VALID(TX_CHAR_VALID), .RX_VALID(RX_VALID), .RX_ACCEPT(RX_ACCEPT),
      .DEV_CLEAR(DEV_CLEAR), .AUTODISC(AUTODISC), .READY_TO_OPERATE(READY_TO_OPERATE));
   smh_modem_model u_modem (.clk(REF_CLK), .rts(LINES_OUT.rts), .dsr_set(dsr),
      .dcd_set(dcd), .cts_allow(allow), .lines(LINES_IN));
   // ****************************************************
   // helpers
   // ****************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge REF_CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge REF_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   // offers one char; lo tells whether request was seen low while waiting
   task automatic send(input logic [7:0] c);
      TX_DATA <= c;
      TX_VALID <= 1'b1;
      lo = 1'b0;
      k = 0;
      do begin
         @(negedge REF_CLK);
         lo |= !LINES_OUT.rts;
         k++;
      end while (TX_READY !== 1'b1 && k < 60);
      chk("rts_cts_at_take", 8'h03, {6'h0, LINES_OUT.rts, LINES_IN.cts});
      @(posedge REF_CLK);
   endtask
   task automatic look(input string nm, input logic [7:0] e, input logic [7:0] g);
      chk(nm, e, g);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ****************************************************
   // reference: chars taken must come out in order
   // ****************************************************
   always @(posedge REF_CLK) begin
      cyc++;
      if (TX_CHAR_VALID === 1'b1) begin
         if (q.size() == 0) chk("tx_char_unexpected", 8'h00, 8'h01);
         else chk("tx_char", q.pop_front(), TX_CHAR);
      end
      if (TX_VALID && TX_READY === 1'b1) begin
         q.push_back(TX_DATA);
      end
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   // ****************************************************
   // scenarios
   // ****************************************************
   initial begin
      repeat (15) @(posedge REF_CLK);
      @(negedge REF_CLK);
      look("outs_in_reset", 8'h00, {5'h0, READY_TO_OPERATE, LINES_OUT});
      @(posedge REF_CLK);
      RST_N <= 1'b1;
      repeat (4) @(posedge REF_CLK);
      rd(4'h0); chk("unmapped", 8'h00, d);
      rd(OFS_EOL_FIRST); chk("eol_first", EOL_FIRST_RST, d);
      rd(OFS_EOL_SECOND); chk("eol_second", EOL_SECOND_RST, d);
      rd(OFS_OBSERVE); chk("observe", 8'h00, d);
      @(negedge REF_CLK);
      look("outs_default", 8'h03, {6'h0, LINES_OUT});
      look("ready", 8'h01, 8'(READY_TO_OPERATE));
      $display("test defaults done");
      for (i = 0; i < 12; i++) begin
         if (i == 6) wr(OFS_OBSERVE, 8'h0E);
         @(posedge REF_CLK);
         r = lfsr(r);
         dsr <= r[0];
         dcd <= r[1];
         allow <= r[2];
         RX_VALID <= r[3];
         TX_VALID <= 1'b1;
         TX_DATA <= r[15:8];
         rd(OFS_STATUS_AUTO);
         repeat (4) @(posedge REF_CLK);
         rd(OFS_STATUS_AUTO); chk("status", {5'h0, r[0], r[2], r[1]}, d);
         @(negedge REF_CLK);
         look("rx_accept", 8'(r[3] && (i < 6 || (r[0] && r[1]))), 8'(RX_ACCEPT));
         look("tx_gate", 8'(i < 6 || (r[0] && r[2])), 8'(TX_READY));
      end
      @(posedge REF_CLK);
      TX_VALID <= 1'b0;
      wr(OFS_OBSERVE, 8'h04);
      dsr <= 1'b0;
      dcd <= 1'b1;
      allow <= 1'b1;
      $display("test observe done");
      for (i = 0; i < 3; i++) begin
         wr(OFS_OVERRIDE, i == 0 ? 8'h04 : (i == 1 ? 8'h0E : 8'h08));
         repeat (3) @(posedge REF_CLK);
         @(negedge REF_CLK);
         look("override", i == 2 ? 8'h01 : 8'h02, {6'h0, LINES_OUT});
      end
      wr(OFS_OVERRIDE, 8'h00);
      AUTODISC <= 1'b1;
      repeat (8) @(posedge REF_CLK);
      @(negedge REF_CLK);
      look("autodisc", 8'h01, {6'h0, LINES_OUT});
      @(posedge REF_CLK);
      AUTODISC <= 1'b0;
      $display("test override done");
      wr(OFS_STATUS_AUTO, 8'h08);
      repeat (4) @(posedge REF_CLK);
      @(negedge REF_CLK);
      look("rts_empty", 8'h00, 8'(LINES_OUT.rts));
      @(posedge REF_CLK);
      r = lfsr(r);
      send({2'b01, r[5:0]}); chk("rts_low_first", 8'h01, 8'(lo));
      send(EOL_FIRST_RST);
      send(EOL_SECOND_RST);
      send({2'b01, r[11:6]}); chk("rts_eol_drop", 8'h01, 8'(lo));
      TX_VALID <= 1'b0;
      repeat (5) @(posedge REF_CLK);
      @(negedge REF_CLK);
      look("rts_drained", 8'h00, 8'(LINES_OUT.rts));
      $display("test auto request done");
      for (i = 0; i < 2; i++) begin
         @(posedge REF_CLK);
         allow <= 1'b0;
         TX_VALID <= 1'b1;
         repeat (10) @(posedge REF_CLK);
         @(negedge REF_CLK);
         look("stall", 8'h02, {6'h0, LINES_OUT.rts, TX_READY});
         if (i == 0) wr(OFS_CONTROL, 8'h01);
         else begin
            @(posedge REF_CLK);
            DEV_CLEAR <= 1'b1;
            @(posedge REF_CLK);
            DEV_CLEAR <= 1'b0;
         end
         lo = 1'b0;
         repeat (6) begin
            @(negedge REF_CLK);
            lo |= !LINES_OUT.rts;
         end
         look("clear_restart", 8'h01, 8'(lo));
         @(posedge REF_CLK);
         TX_VALID <= 1'b0;
         allow <= 1'b1;
         repeat (4) @(posedge REF_CLK);
      end
      $display("test clear done");
      repeat (4) @(posedge REF_CLK);
      summarize();
   end
endmodule
